// ---- shared/charge_regs.vh ----
// charge_regs.vh: register offsets, field positions, reset values and timing figures
// assumes: included by bare name from the charge sequencer design files
`ifndef CHARGE_REGS_VH
`define CHARGE_REGS_VH

// register byte offsets
`define REG_CTRL_OFS      8'h00
`define REG_STATUS_OFS    8'h04
`define REG_TIMER_OFS     8'h08

// control fields
`define CTRL_HOURS_LSB    0
`define CTRL_HOURS_MSB    4
`define CTRL_RESET_VAL    5'h03

// status fields
`define STAT_STATE_LSB    0
`define STAT_STATE_MSB    7
`define STAT_TIMER_EN     8
`define STAT_CV_REG       9
`define STAT_OUT_ON       10
`define STAT_RECHARGE     11

// cc duration range in hours for the value written to the control register
`define CC_HOURS_MIN      5'h02
`define CC_HOURS_MAX      5'h10

// timing figures in their own units
`define CLK_MHZ           125
`define TICK_US           100
`define GND_PULSE_US      300
`define PRE_MINUTES       45
`define CC_FIXED_HOURS    3
`define CV_HOURS          3
`define TOPOFF_MINUTES    45
`define HOLD_SECONDS      22
`define US_PER_S          1000000

// axi answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- logic/tick_gen.v ----
// tick_gen.v: single timebase that emits one-cycle ticks for all stage timing
// assumes: one clock, synchronous clock enable, asynchronous active-low reset
`timescale 1ns/10ps

module tick_gen #(
  parameter TICK_CYC = 12500
) (
  // clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_ce,
  // tick out
  output reg  o_tick
);

  reg [31:0] cnt_q;

  // free-running divider, pulse on wrap
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= 32'h0000_0000;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      if (cnt_q >= TICK_CYC - 1) begin
        cnt_q  <= 32'h0000_0000;
        o_tick <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 32'h0000_0001;
        o_tick <= 1'b0;
      end
    end
  end

endmodule // tick_gen

// ---- logic/charge_stage_timer_status.v ----
// charge_stage_timer_status.v: charge cycle sequencer, stage timers, status pins
// assumes: comparator and pin-state inputs are synchronous to i_clk; AXI4-Lite slave
//
// How it works
// RULE1 - precharge not passed in 45 min: fault
// RULE2 - precharge timeout runs even with timer off
// RULE3 - crossing precharge threshold restarts timer for cc
// RULE4 - cc duration elapses before target: fault
// RULE5 - no cc fault timer when timer disabled
// RULE6 - cc duration fixed 3h or 2..16h programmed
// RULE7 - at target: clear timer, 3h cv timer
// RULE8 - terminate on low current or cv expiry
// RULE9 - timer enabled: 45 min top-off, then monitor
// RULE10 - pin grounded: no timer, terminate straight to monitor
// RULE11 - ground pulse in cc restarts cc timer
// RULE12 - ground pulse in top-off ends cycle now
// RULE13 - temperature fault freezes timer, resumes later
// RULE14 - status pins open-drain, low when asserted
// RULE15 - source-present asserted when input supply valid
// RULE16 - indicator on while charging, off otherwise
// RULE17 - indicator stays 22 s after termination
// RULE18 - automatic recharge leaves indicator released
// RULE19 - fault: indicator asserted, source-present released
// RULE20 - no valid supply: both pins released
// RULE21 - current regulation until 7mV above target
// RULE22 - back to current when 5% over
// RULE23 - disable input: output off, timer cleared
// RULE24 - no battery: timer off, cleared on return
// RULE25 - one timebase; transitions on next tick
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "charge_regs.vh"

module charge_stage_timer_status #(
  parameter TICK_CYC   = `TICK_US * `CLK_MHZ,
  parameter GND_CYC    = `GND_PULSE_US * `CLK_MHZ,
  parameter TPS        = `US_PER_S / `TICK_US,
  parameter PRE_TICKS  = `PRE_MINUTES * 60 * TPS,
  parameter HOUR_TICKS = 3600 * TPS,
  parameter TOP_TICKS  = `TOPOFF_MINUTES * 60 * TPS,
  parameter HOLD_TICKS = `HOLD_SECONDS * TPS
) (
  // clock, reset, enable
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // analog comparator results
  input  wire        i_vin_valid,
  input  wire        i_en_disabled,
  input  wire        i_no_battery,
  input  wire        i_temp_fault,
  input  wire        i_iprog_short,
  input  wire        i_vbat_above_pre,
  input  wire        i_vbat_at_target,
  input  wire        i_vbat_above_transition,
  input  wire        i_vbat_below_recharge,
  input  wire        i_iout_below_term,
  input  wire        i_iout_above_fast,
  // timer programming pin state
  input  wire        i_timer_pin_gnd,
  input  wire        i_timer_pin_vsys,
  // charger output control
  output reg         o_output_on,
  output reg         o_cv_regulation,
  // open-drain status pins
  output reg         o_source_present_n_o,
  output reg         o_source_present_n_oe,
  output reg         o_charging_indicator_n_o,
  output reg         o_charging_indicator_n_oe,
  // axi4-lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // one-hot states
  localparam [7:0] ST_IDLE  = 8'h01;
  localparam [7:0] ST_PRE   = 8'h02;
  localparam [7:0] ST_CC    = 8'h04;
  localparam [7:0] ST_CV    = 8'h08;
  localparam [7:0] ST_TOP   = 8'h10;
  localparam [7:0] ST_MON   = 8'h20;
  localparam [7:0] ST_FAULT = 8'h40;
  localparam [7:0] ST_NOBAT = 8'h80;

  reg  [7:0]  state_q;
  reg  [31:0] timer_q;
  reg  [31:0] hold_q;
  reg  [31:0] gnd_cnt_q;
  reg         gnd_pulse_q;
  reg         timer_en_q;
  reg         recharge_q;
  reg  [4:0]  hours_q;
  reg  [7:0]  aw_addr_q;
  reg         aw_got_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_got_q;
  wire        tick;
  wire        pulse_seen;
  wire        pulse_take;
  wire        timing;
  wire        charging;
  wire        temp_hold;
  wire [4:0]  hours_c;
  wire [31:0] cc_limit;

  // shared timebase
  tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .o_tick  (tick)
  ); // RULE25

  // stage and condition decode
  assign charging  = |(state_q & (ST_PRE | ST_CC | ST_CV | ST_TOP));
  assign temp_hold = i_temp_fault & charging;
  assign timing    = charging & ~temp_hold; // RULE13
  assign hours_c   = (hours_q < `CC_HOURS_MIN) ? `CC_HOURS_MIN :
                     (hours_q > `CC_HOURS_MAX) ? `CC_HOURS_MAX : hours_q;
  assign cc_limit  = i_timer_pin_vsys ? `CC_FIXED_HOURS * HOUR_TICKS :
                     hours_c * HOUR_TICKS; // RULE6

  // release after a long enough ground marks a host pulse
  assign pulse_seen = ~i_timer_pin_gnd & (gnd_cnt_q >= GND_CYC);
  assign pulse_take = tick & gnd_pulse_q & ~pulse_seen;

  // ground pulse width measurement, set wins over consume
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gnd_cnt_q   <= 32'h0000_0000;
      gnd_pulse_q <= 1'b0;
    end else if (i_ce) begin
      if (!i_timer_pin_gnd)
        gnd_cnt_q <= 32'h0000_0000;
      else if (gnd_cnt_q < GND_CYC)
        gnd_cnt_q <= gnd_cnt_q + 32'h0000_0001;
      if (pulse_seen)
        gnd_pulse_q <= 1'b1;
      else if (pulse_take)
        gnd_pulse_q <= 1'b0;
    end
  end

  // charge cycle sequencer with stage timer
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= ST_IDLE;
      timer_q    <= 32'h0000_0000;
      hold_q     <= 32'h0000_0000;
      timer_en_q <= 1'b0;
      recharge_q <= 1'b0;
    end else if (i_ce) begin
      if (tick && hold_q != 32'h0000_0000)
        hold_q <= hold_q - 32'h0000_0001;
      if (!i_vin_valid || i_en_disabled) begin
        state_q <= ST_IDLE; // RULE23
        timer_q <= 32'h0000_0000; // RULE23
        hold_q  <= 32'h0000_0000;
      end else if (tick && charging && i_no_battery) begin
        state_q <= ST_NOBAT; // RULE24
        timer_q <= 32'h0000_0000; // RULE24
      end else if (tick) begin
        if (timing)
          timer_q <= timer_q + 32'h0000_0001; // RULE25
        case (state_q)
          ST_IDLE: begin
            timer_q <= 32'h0000_0000;
            if (i_no_battery) begin
              state_q <= ST_NOBAT;
            end else begin
              state_q    <= ST_PRE;
              recharge_q <= 1'b0;
              timer_en_q <= ~i_timer_pin_gnd;
            end
          end
          ST_NOBAT: begin
            timer_q <= 32'h0000_0000; // RULE24
            if (!i_no_battery)
              state_q <= ST_IDLE; // RULE24
          end
          ST_PRE: begin
            if (i_iprog_short) begin
              state_q <= ST_FAULT; // RULE19
            end else if (i_vbat_above_pre) begin
              state_q <= ST_CC;
              timer_q <= 32'h0000_0000; // RULE3
            end else if (timing && timer_q + 32'h0000_0001 >= PRE_TICKS) begin
              state_q <= ST_FAULT; // RULE1 RULE2
            end
          end
          ST_CC: begin
            if (i_iprog_short) begin
              state_q <= ST_FAULT;
            end else if (i_vbat_at_target) begin
              state_q <= ST_CV;
              timer_q <= 32'h0000_0000; // RULE7
            end else if (timer_en_q && gnd_pulse_q) begin
              timer_q <= 32'h0000_0000; // RULE11
            end else if (timer_en_q && timing && timer_q + 32'h0000_0001 >= cc_limit) begin
              state_q <= ST_FAULT; // RULE4 RULE5
            end
          end
          ST_CV: begin
            if (i_iprog_short) begin
              state_q <= ST_FAULT;
            end else if (timing && (i_iout_below_term || (timer_en_q &&
                         timer_q + 32'h0000_0001 >= `CV_HOURS * HOUR_TICKS))) begin
              timer_q <= 32'h0000_0000; // RULE8
              hold_q  <= recharge_q ? 32'h0000_0000 : HOLD_TICKS; // RULE17
              state_q <= timer_en_q ? ST_TOP : ST_MON; // RULE9 RULE10
            end
          end
          ST_TOP: begin
            if (gnd_pulse_q) begin
              state_q <= ST_MON; // RULE12
              timer_q <= 32'h0000_0000;
            end else if (timing && timer_q + 32'h0000_0001 >= TOP_TICKS) begin
              state_q <= ST_MON; // RULE9
              timer_q <= 32'h0000_0000;
            end
          end
          ST_MON: begin
            timer_q <= 32'h0000_0000;
            if (i_no_battery) begin
              state_q <= ST_NOBAT;
            end else if (i_vbat_below_recharge) begin
              state_q    <= ST_PRE;
              recharge_q <= 1'b1; // RULE18
              timer_en_q <= ~i_timer_pin_gnd;
            end
          end
          ST_FAULT: begin
            timer_q <= timer_q;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // logical cc/cv regulation switch
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cv_regulation <= 1'b0;
      o_output_on     <= 1'b0;
    end else if (i_ce) begin
      o_output_on <= (charging & ~temp_hold) | (state_q == ST_NOBAT); // RULE13 RULE24
      if (!(charging || state_q == ST_NOBAT))
        o_cv_regulation <= 1'b0;
      else if (state_q == ST_TOP || state_q == ST_NOBAT)
        o_cv_regulation <= 1'b1;
      else if (o_cv_regulation && i_iout_above_fast)
        o_cv_regulation <= 1'b0; // RULE22
      else if (i_vbat_above_transition)
        o_cv_regulation <= 1'b1; // RULE21
    end
  end

  // open-drain status pins, only ever pulled low
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_source_present_n_o      <= 1'b0;
      o_source_present_n_oe     <= 1'b0;
      o_charging_indicator_n_o  <= 1'b0;
      o_charging_indicator_n_oe <= 1'b0;
    end else if (i_ce) begin
      o_source_present_n_o     <= 1'b0; // RULE14
      o_charging_indicator_n_o <= 1'b0; // RULE14
      if (!i_vin_valid) begin
        o_source_present_n_oe     <= 1'b0; // RULE20
        o_charging_indicator_n_oe <= 1'b0; // RULE20
      end else if (!i_en_disabled && (state_q == ST_FAULT || temp_hold ||
                   (i_iprog_short && charging))) begin
        o_source_present_n_oe     <= 1'b0; // RULE19
        o_charging_indicator_n_oe <= 1'b1; // RULE19
      end else begin
        o_source_present_n_oe     <= 1'b1; // RULE15
        o_charging_indicator_n_oe <= ~i_en_disabled & ~recharge_q &
          ((|(state_q & (ST_PRE | ST_CC | ST_CV))) ||
           (hold_q != 32'h0000_0000 && (state_q == ST_TOP || state_q == ST_MON)));
        // RULE16 RULE17 RULE18
      end
    end
  end

  // axi write channel: address and data taken in either order
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      hours_q       <= `CTRL_RESET_VAL;
    end else if (i_ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_got_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_got_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        if (aw_addr_q[7:2] == `REG_CTRL_OFS >> 2) begin
          s_axi_bresp <= `RESP_OKAY;
          if (w_strb_q[0])
            hours_q <= w_data_q[`CTRL_HOURS_MSB:`CTRL_HOURS_LSB];
        end else if (aw_addr_q[7:2] == `REG_STATUS_OFS >> 2 ||
                     aw_addr_q[7:2] == `REG_TIMER_OFS >> 2) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read channel, one cycle to answer
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (i_ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RESP_OKAY;
        case (s_axi_araddr[7:2])
          `REG_CTRL_OFS >> 2:   s_axi_rdata <= {27'h000_0000, hours_q};
          `REG_STATUS_OFS >> 2: s_axi_rdata <= {20'h0_0000, recharge_q, o_output_on,
                                                o_cv_regulation, timer_en_q, state_q};
          `REG_TIMER_OFS >> 2:  s_axi_rdata <= timer_q;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // charge_stage_timer_status

// ---- sim/charge_stage_timer_status_props.sv ----
// charge_stage_timer_status_props.sv: assertions on status pins, output and bus
// assumes: bound to the sequencer top, i_ce held high, timebase tick of 4 cycles
`timescale 1ns/10ps

module charge_stage_timer_status_props (
  // clock and reset
  input logic        i_clk,
  input logic        i_rst_n,
  // comparator inputs
  input logic        i_vin_valid,
  input logic        i_en_disabled,
  input logic        i_no_battery,
  input logic        i_vbat_above_transition,
  input logic        i_iout_above_fast,
  // output control and status pins
  input logic        o_output_on,
  input logic        o_cv_regulation,
  input logic        o_source_present_n_o,
  input logic        o_source_present_n_oe,
  input logic        o_charging_indicator_n_o,
  input logic        o_charging_indicator_n_oe,
  // bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // supply gone or charger disabled for two samples
  sequence vin_gone;
    !i_vin_valid ##1 !i_vin_valid;
  endsequence
  sequence held_off;
    i_en_disabled ##1 i_en_disabled;
  endsequence

  od_low_a: assert property (!o_source_present_n_o && !o_charging_indicator_n_o)
    else $error("status pin data not low");
  src_vin_a: assert property (o_source_present_n_oe |-> $past(i_vin_valid))
    else $error("source present without supply");
  vin_loss_a: assert property (vin_gone |=> !o_source_present_n_oe && !o_charging_indicator_n_oe)
    else $error("pins held without supply");
  disable_off_a: assert property (held_off |=> !o_output_on && !o_charging_indicator_n_oe)
    else $error("output or indicator on while disabled");
  nobat_rel_a: assert property (i_no_battery [*8] |-> !o_charging_indicator_n_oe)
    else $error("indicator on without battery");
  cv_revert_a: assert property ((i_iout_above_fast && !i_vbat_above_transition
    && !i_no_battery) [*8] |-> !o_cv_regulation)
    else $error("voltage regulation kept at high current");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready while busy");
  b_after_a: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("write answer before both taken");
endmodule // charge_stage_timer_status_props

bind charge_stage_timer_status charge_stage_timer_status_props chk (.i_clk, .i_rst_n,
  .i_vin_valid, .i_en_disabled, .i_no_battery, .i_vbat_above_transition, .i_iout_above_fast,
  .o_output_on, .o_cv_regulation, .o_source_present_n_o, .o_source_present_n_oe,
  .o_charging_indicator_n_o, .o_charging_indicator_n_oe, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- sim/host_gpio_model.sv ----
// host_gpio_model.sv: host side of the status pins and the timer pin
// assumes: status pins pulled up, host grounds the timer pin on command
`timescale 1ns/10ps

module host_gpio_model (
  // clock
  input  logic i_clk,
  // open-drain status pins
  input  logic i_src_o,
  input  logic i_src_oe,
  input  logic i_ind_o,
  input  logic i_ind_oe,
  // resolved levels and timer pin ground
  output logic o_src_pin,
  output logic o_ind_pin,
  output logic o_pin_gnd = 1'b0
);
  // pull-up wins while a pin is released
  assign o_src_pin = i_src_oe ? i_src_o : 1'b1;
  assign o_ind_pin = i_ind_oe ? i_ind_o : 1'b1;

  // ground the timer pin for n clocks, then let go
  task automatic press(input int n);
    o_pin_gnd <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_pin_gnd <= 1'b0;
  endtask
endmodule // host_gpio_model

// ---- sim/test_charge_stage_timer_status.sv ----
// test_charge_stage_timer_status.sv: scenario bench for the charge sequencer
// assumes: shortened timing parameters, host model on the status and timer pins
`timescale 1ns/10ps
`include "charge_regs.vh"
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH %0t %s", $time, m); end end

module test_charge_stage_timer_status;
  // clock, reset and comparator drives
  logic        i_clk = 0, i_rst_n = 0, i_ce = 1, i_vin_valid = 0, i_en_disabled = 0;
  logic        i_no_battery = 0, i_temp_fault = 0, i_iprog_short = 0, i_vbat_above_pre = 0;
  logic        i_vbat_at_target = 0, i_vbat_above_transition = 0, i_vbat_below_recharge = 0;
  logic        i_iout_below_term = 0, i_iout_above_fast = 0, i_timer_pin_vsys = 0;
  logic        i_timer_pin_gnd, src_pin, ind_pin, o_output_on, o_cv_regulation;
  logic        o_source_present_n_o, o_source_present_n_oe;
  logic        o_charging_indicator_n_o, o_charging_indicator_n_oe;
  // bus
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, t1;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  int          err_count = 0, check_count = 0, cyc = 0, c0;

  charge_stage_timer_status #(.TICK_CYC(4), .GND_CYC(8), .HOUR_TICKS(20), .PRE_TICKS(10),
    .TOP_TICKS(10), .HOLD_TICKS(5)) dut (.i_clk, .i_rst_n, .i_ce, .i_vin_valid,
    .i_en_disabled, .i_no_battery, .i_temp_fault, .i_iprog_short, .i_vbat_above_pre,
    .i_vbat_at_target, .i_vbat_above_transition, .i_vbat_below_recharge,
    .i_iout_below_term, .i_iout_above_fast, .i_timer_pin_gnd, .i_timer_pin_vsys,
    .o_output_on, .o_cv_regulation, .o_source_present_n_o, .o_source_present_n_oe,
    .o_charging_indicator_n_o, .o_charging_indicator_n_oe, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  host_gpio_model host (.i_clk, .i_src_o(o_source_present_n_o),
    .i_src_oe(o_source_present_n_oe), .i_ind_o(o_charging_indicator_n_o),
    .i_ind_oe(o_charging_indicator_n_oe), .o_src_pin(src_pin), .o_ind_pin(ind_pin),
    .o_pin_gnd(i_timer_pin_gnd));

  // clock and hang guard
  initial forever #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // bus write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1;
    do @(posedge i_clk); while (!s_axi_bvalid);
    `CHK(s_axi_bresp, r, "write response")
    s_axi_bready <= 0;
    @(posedge i_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge i_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge i_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge i_clk);
  endtask

  // poll the state field until it shows s
  task automatic wait_state(input logic [7:0] s);
    int n = 0;
    do begin
      axi_rd(`REG_STATUS_OFS);
      n++;
    end while (rd[7:0] !== s && n < 300);
    `CHK(rd[7:0], s, "state")
  endtask

  task automatic restart;
    i_vin_valid <= 0;
    repeat (4) @(posedge i_clk);
    `CHK({src_pin, ind_pin}, 2'b11, "no supply")
    i_vin_valid <= 1;
  endtask

  task automatic t_regs;
    axi_rd(`REG_CTRL_OFS);
    `CHK(rd, `CTRL_RESET_VAL, "ctrl reset")
    axi_wr(`REG_CTRL_OFS, 32'h0000_0005, `RESP_OKAY);
    axi_rd(`REG_CTRL_OFS);
    `CHK(rd[4:0], 5'h05, "ctrl rw")
    s_axi_wstrb <= 4'he;
    axi_wr(`REG_CTRL_OFS, 32'h0000_0009, `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axi_rd(`REG_CTRL_OFS);
    `CHK(rd[4:0], 5'h05, "strobe off")
    axi_wr(8'h40, 32'h0000_0001, `RESP_SLVERR);
    axi_rd(8'h40);
    `CHK(rr, `RESP_SLVERR, "unmapped read")
    $display("test regs done");
  endtask

  // full cycle, recharge and top-off cut short by a ground pulse
  task automatic t_cycle;
    i_vbat_above_pre <= 1;
    i_vin_valid <= 1;
    wait_state(8'h04);
    `CHK({src_pin, ind_pin}, 2'b00, "charging pins")
    i_vbat_at_target <= 1;
    i_vbat_above_transition <= 1;
    wait_state(8'h08);
    `CHK(o_cv_regulation, 1'b1, "cv regulation")
    i_vbat_above_transition <= 0;
    i_iout_above_fast <= 1;
    repeat (12) @(posedge i_clk);
    `CHK(o_cv_regulation, 1'b0, "back to current")
    i_iout_above_fast <= 0;
    i_iout_below_term <= 1;
    wait_state(8'h10);
    `CHK(ind_pin, 1'b0, "hold after end")
    repeat (28) @(posedge i_clk);
    `CHK({ind_pin, o_output_on}, 2'b11, "top-off quiet")
    wait_state(8'h20);
    `CHK(o_output_on, 1'b0, "monitor off")
    i_iout_below_term <= 0;
    i_vbat_below_recharge <= 1;
    wait_state(8'h08);
    `CHK({rd[11], ind_pin, o_output_on}, 3'b111, "recharge")
    i_vbat_below_recharge <= 0;
    i_iout_below_term <= 1;
    wait_state(8'h10);
    `CHK(ind_pin, 1'b1, "no hold in recharge")
    host.press(12);
    repeat (6) @(posedge i_clk);
    axi_rd(`REG_STATUS_OFS);
    `CHK({rd[8], rd[7:0]}, 9'h120, "pulse ends top-off")
    i_iout_below_term <= 0;
    $display("test cycle done");
  endtask

  // fixed cc limit, watchdog restart, freeze, disable, battery removal
  task automatic t_cc;
    i_vbat_at_target <= 0;
    i_timer_pin_vsys <= 1;
    restart();
    wait_state(8'h04);
    repeat (160) @(posedge i_clk);
    host.press(12);
    c0 = cyc;
    repeat (140) @(posedge i_clk);
    axi_rd(`REG_STATUS_OFS);
    `CHK(rd[7:0], 8'h04, "cc extended")
    wait_state(8'h40);
    `CHK(cyc - c0 inside {[238:258]}, 1'b1, "cc limit")
    `CHK({src_pin, ind_pin}, 2'b10, "fault pins")
    restart();
    wait_state(8'h04);
    i_temp_fault <= 1;
    repeat (10) @(posedge i_clk);
    axi_rd(`REG_TIMER_OFS);
    t1 = rd;
    repeat (30) @(posedge i_clk);
    axi_rd(`REG_TIMER_OFS);
    `CHK(rd, t1, "timer frozen")
    `CHK({src_pin, ind_pin}, 2'b10, "temp fault pins")
    i_temp_fault <= 0;
    repeat (30) @(posedge i_clk);
    axi_rd(`REG_TIMER_OFS);
    `CHK(rd > t1, 1'b1, "timer resumed")
    t1 = rd;
    i_ce <= 0;
    repeat (40) @(posedge i_clk);
    i_ce <= 1;
    axi_rd(`REG_TIMER_OFS);
    `CHK(rd - t1 < 32'h0000_0002, 1'b1, "enable freeze")
    i_en_disabled <= 1;
    repeat (8) @(posedge i_clk);
    axi_rd(`REG_TIMER_OFS);
    `CHK({rd, ind_pin}, {32'h0000_0000, 1'b1}, "disabled")
    i_en_disabled <= 0;
    i_no_battery <= 1;
    wait_state(8'h80);
    `CHK({src_pin, ind_pin}, 2'b01, "no battery pins")
    i_no_battery <= 0;
    $display("test cc done");
  endtask

  // precharge limit with the timer pin grounded
  task automatic t_pre;
    i_timer_pin_vsys <= 0;
    i_vbat_above_pre <= 0;
    fork
      host.press(40);
      restart();
    join
    wait_state(8'h40);
    `CHK(rd[8], 1'b0, "timer off")
    `CHK({src_pin, ind_pin}, 2'b10, "pre fault pins")
    i_iprog_short <= 1;
    i_vbat_above_pre <= 1;
    restart();
    repeat (12) @(posedge i_clk);
    axi_rd(`REG_STATUS_OFS);
    `CHK({rd[7:0], src_pin, ind_pin}, 10'h102, "short fault")
    i_iprog_short <= 0;
    $display("test pre done");
  endtask

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1;
    @(posedge i_clk);
    t_regs();
    t_cycle();
    t_cc();
    t_pre();
    conclude();
  end
endmodule // test_charge_stage_timer_status
